// ### cfe_core.sv
// fetch/execute sequencer of a small 8-bit core with 12-bit instructions
// assumes program memory answers combinationally on sys_clk, pins are async
//
// Notes on behaviour
// (RL1) clock divided by four into phases
// (RL2) counter advances phase one, latch phase four
// (RL3) execute in the cycle after fetch
// (RL4) operand read phase two, write phase four
// (RL5) branches take two cycles, prefetch dropped
// (RL6) program counter is twelve bits wide
// (RL7) addresses wrap into implemented program space
// (RL8) reset starts fetching at address zero
// (RL9) calibration word must stay unprogrammed
// (RL10) larger variant pages program via status bit
// (RL11) larger variant banks data via pointer
// (RL12) small file: 7 special, 25 general
// (RL13) larger adds 16 banked general registers
// (RL14) general registers direct and indirect reachable
// (RL15) pins zero/one programming clock, data, hysteresis
// (RL16) per-pin pull-up and wake enables
// (RL17) pin two port bit or timer clock
// (RL18) pin three input; master clear resets
// (RL19) master clear forces pin three pull-up
// (RL20) pin four crystal output in crystal modes
// (RL21) pin five oscillator input unless internal RC
// (RL22) status page bit supplies upper address
// (RL23) flushed slot acts as no-operation
`include "cfe_params.svh"
`timescale 1ns/1ps
`default_nettype none

module cfe_core #(
  parameter bit LARGE_VARIANT = 1'b1
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [11:0] prog_addr,
  input wire logic [11:0] prog_data,
  input wire logic [5:0] port_pin_in,
  output cfe_pkg::cfe_pin_drive_t port_pin_drive,
  output logic [5:0] pullup_en,
  output logic pin01_schmitt,
  input wire logic prog_mode,
  output logic ser_prog_clk,
  output logic ser_prog_dat,
  output logic osc_output_en,
  output logic osc_input_sel,
  output cfe_pkg::cfe_phases_t phases,
  output logic core_in_reset
);

  // op decode, used by execute and by the flush logic
  function automatic cfe_pkg::cfe_op_t decode(input logic [11:0] ir);
    decode = cfe_pkg::OP_NOP;
    if (ir[11:9] == 3'h5) decode = cfe_pkg::OP_GOTO;
    else if (ir[11:8] == 4'hC) decode = cfe_pkg::OP_MOVLW;
    else if (ir[11:8] == 4'h4) decode = cfe_pkg::OP_BCF;
    else if (ir[11:8] == 4'h5) decode = cfe_pkg::OP_BSF;
    else if (ir[11:5] == 7'h01) decode = cfe_pkg::OP_MOVWF;
    else if (ir[11:5] == 7'h03) decode = cfe_pkg::OP_CLRF;
    else if (ir[11:6] == 6'h08) decode = cfe_pkg::OP_MOVF;
    else if (ir[11:6] == 6'h0A) decode = cfe_pkg::OP_INCF;
    else if (ir[11:6] == 6'h07) decode = cfe_pkg::OP_ADDWF;
    else if (ir == 12'h003) decode = cfe_pkg::OP_SLEEP;
    else if (ir == 12'h006) decode = cfe_pkg::OP_TRIS;
  endfunction

  // slot of a general register: bank one holds the 16 extra ones
  function automatic logic [5:0] gpr_slot(input logic [4:0] a, input logic bank);
    if (bank && a >= `CFE_F_BANKED) gpr_slot = 6'({1'b0, a} + 6'h09);
    else gpr_slot = 6'({1'b0, a} - 6'h07);
  endfunction

  // synchronisers
  logic [5:0] pin_meta_q, pin_sync_q, pin_prev_q;
  logic prog_meta_q, prog_sync_q;
  // configuration and pin options from apb
  logic [3:0] cfg_q;
  logic [5:0] pull_q, wake_en_q;
  logic [31:0] prdata_q;
  logic pslverr_q;
  // core state
  cfe_pkg::cfe_phase_t ph_q;
  logic [11:0] pc_q, fetch_addr_q, ir_q;
  logic ir_valid_q, sleeping_q, wake_q;
  logic [7:0] w_q, status_q, ptr_q, osccal_q, timer_q, operand_q;
  logic [5:0] tris_q, gpio_q, pin_snap_q;
  logic [7:0] gpr_q [`CFE_GPR_SLOTS];
  // combinational
  logic core_rst, master_clear_n_hit, running, exec_now, ptr_bank, page_eff;
  logic [11:0] prog_mask;
  logic [4:0] eff_addr;
  logic [7:0] file_rd, res_d, st_d;
  logic wr_file, wr_w, z_en, c_en, z_d, c_d, dc_d, branch;
  logic [8:0] sum9;
  cfe_pkg::cfe_op_t op;
  cfe_pkg::cfe_osc_t osc_mode;

  // two-flop synchronisers for pins and programming entry
  always_ff @(posedge sys_clk) begin
    pin_meta_q <= port_pin_in;
    pin_sync_q <= pin_meta_q;
    pin_prev_q <= pin_sync_q;
    prog_meta_q <= prog_mode;
    prog_sync_q <= prog_meta_q;
  end

  // reset sources; the apb configuration only follows rst_n
  assign osc_mode = cfe_pkg::cfe_osc_t'(cfg_q[`CFE_CFG_OSC_LO +: 2]);
  assign master_clear_n_hit = cfg_q[`CFE_CFG_MASTER_CLEAR_N] && !pin_sync_q[3]; // see (RL18)
  assign core_rst = !rst_n || master_clear_n_hit || prog_sync_q || wake_q;
  assign core_in_reset = core_rst;
  assign running = !sleeping_q;

  // variant dependent program space and banking
  assign prog_mask = LARGE_VARIANT ? `CFE_LARGE_MASK : `CFE_SMALL_MASK;
  assign ptr_bank = LARGE_VARIANT && ptr_q[`CFE_PTR_BANK]; // see (RL11) (RL13)
  assign page_eff = LARGE_VARIANT && status_q[`CFE_ST_PAGE]; // see (RL10) (RL22)

  // phase divider: four sys_clk periods per instruction cycle
  always_ff @(posedge sys_clk) begin
    if (core_rst) begin
      ph_q <= cfe_pkg::PH_ONE;
    end else if (running) begin
      ph_q <= cfe_pkg::cfe_phase_t'(ph_q + 2'h1); // see (RL1)
    end
  end
  assign phases.phase_one = running && ph_q == cfe_pkg::PH_ONE;
  assign phases.phase_two = running && ph_q == cfe_pkg::PH_TWO;
  assign phases.phase_three = running && ph_q == cfe_pkg::PH_THREE;
  assign phases.phase_four = running && ph_q == cfe_pkg::PH_FOUR;

  // program counter and fetch address
  always_ff @(posedge sys_clk) begin
    if (core_rst) begin
      pc_q <= `CFE_RESET_VECTOR; // see (RL8)
      fetch_addr_q <= `CFE_RESET_VECTOR;
    end else if (phases.phase_one) begin
      fetch_addr_q <= pc_q & prog_mask; // see (RL7)
      pc_q <= pc_q + 12'h001; // see (RL2) (RL6)
    end else if (exec_now && op == cfe_pkg::OP_GOTO) begin
      pc_q <= {2'h0, page_eff, ir_q[8:0]}; // see (RL5) (RL22)
    end else if (exec_now && wr_file && eff_addr == `CFE_F_PCL) begin
      pc_q <= {2'h0, page_eff, 1'b0, res_d};
    end
  end
  assign prog_addr = fetch_addr_q;

  // instruction latch; a branch marks the prefetched word as dead
  always_ff @(posedge sys_clk) begin
    if (core_rst) begin
      ir_q <= 12'h000;
      ir_valid_q <= 1'b0;
    end else if (phases.phase_four) begin
      ir_q <= prog_data; // see (RL2) (RL3)
      ir_valid_q <= !(exec_now && branch); // see (RL5) (RL23)
    end
  end

  // decode of the word under execution
  assign op = decode(ir_q);
  assign exec_now = phases.phase_four && ir_valid_q; // see (RL4) (RL23)
  assign eff_addr = (ir_q[4:0] == `CFE_F_INDF) ? ptr_q[4:0] : ir_q[4:0]; // see (RL14)
  assign branch = op == cfe_pkg::OP_GOTO || (wr_file && eff_addr == `CFE_F_PCL);

  // file read: special registers, then general ones
  always_comb begin
    file_rd = 8'h00;
    case (eff_addr)
      `CFE_F_INDF: file_rd = 8'h00;
      `CFE_F_TIMER: file_rd = timer_q;
      `CFE_F_PCL: file_rd = pc_q[7:0];
      `CFE_F_STATUS: file_rd = status_q;
      `CFE_F_POINTER: file_rd = LARGE_VARIANT ? {2'h3, ptr_q[5:0]} : {3'h7, ptr_q[4:0]};
      `CFE_F_OSCCAL: file_rd = osccal_q;
      `CFE_F_GPIO: file_rd = {2'h0, pin_sync_q};
      default: file_rd = gpr_q[gpr_slot(eff_addr, ptr_bank)]; // see (RL12) (RL14)
    endcase
  end

  // operand read in phase two
  always_ff @(posedge sys_clk) begin
    if (core_rst) begin
      operand_q <= 8'h00;
    end else if (phases.phase_two) begin
      operand_q <= file_rd; // see (RL4)
    end
  end

  // result and flags of the executing word
  always_comb begin
    res_d = operand_q;
    wr_file = 1'b0;
    wr_w = 1'b0;
    z_en = 1'b0;
    c_en = 1'b0;
    sum9 = {1'b0, operand_q} + {1'b0, w_q};
    dc_d = ({1'b0, operand_q[3:0]} + {1'b0, w_q[3:0]}) > 5'h0F; // carry out of the low nibble
    c_d = sum9[8];
    case (op)
      cfe_pkg::OP_MOVLW: begin
        res_d = ir_q[7:0];
        wr_w = 1'b1;
      end
      cfe_pkg::OP_MOVWF: begin
        res_d = w_q;
        wr_file = 1'b1;
      end
      cfe_pkg::OP_CLRF: begin
        res_d = 8'h00;
        wr_file = 1'b1;
        z_en = 1'b1;
      end
      cfe_pkg::OP_MOVF, cfe_pkg::OP_INCF, cfe_pkg::OP_ADDWF: begin
        if (op == cfe_pkg::OP_INCF) res_d = operand_q + 8'h01;
        else if (op == cfe_pkg::OP_ADDWF) res_d = sum9[7:0];
        wr_file = ir_q[5];
        wr_w = !ir_q[5];
        z_en = 1'b1;
        c_en = op == cfe_pkg::OP_ADDWF;
      end
      cfe_pkg::OP_BCF, cfe_pkg::OP_BSF: begin
        res_d[ir_q[7:5]] = op == cfe_pkg::OP_BSF;
        wr_file = 1'b1;
      end
      default: res_d = operand_q;
    endcase
    z_d = res_d == 8'h00;
  end

  // working register
  always_ff @(posedge sys_clk) begin
    if (core_rst) begin
      w_q <= 8'h00;
    end else if (exec_now && wr_w) begin
      w_q <= res_d; // see (RL4)
    end
  end

  // status: flag bits from logic win over a direct write, TO/PD read only
  always_comb begin
    st_d = status_q;
    if (wr_file && eff_addr == `CFE_F_STATUS) begin
      st_d = {res_d[7:5], status_q[`CFE_ST_TO], status_q[`CFE_ST_PD], res_d[2:0]};
    end
    if (z_en) st_d[`CFE_ST_Z] = z_d;
    if (c_en) begin
      st_d[`CFE_ST_C] = c_d;
      st_d[`CFE_ST_DC] = dc_d;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (core_rst) begin
      status_q <= `CFE_STATUS_RST;
      status_q[`CFE_ST_WAKE] <= wake_q;
      status_q[`CFE_ST_PD] <= !wake_q;
    end else if (exec_now && op == cfe_pkg::OP_SLEEP) begin
      status_q[`CFE_ST_PD] <= 1'b0;
    end else if (exec_now) begin
      status_q <= st_d; // see (RL22)
    end
  end

  // pointer, calibration, direction and port latch
  always_ff @(posedge sys_clk) begin
    if (core_rst) begin
      ptr_q <= 8'h00;
      osccal_q <= `CFE_OSCCAL_RST;
      tris_q <= `CFE_TRIS_RST;
      gpio_q <= 6'h00;
    end else if (exec_now) begin
      if (wr_file && eff_addr == `CFE_F_POINTER) ptr_q <= res_d; // see (RL11)
      if (wr_file && eff_addr == `CFE_F_OSCCAL) osccal_q <= res_d;
      if (wr_file && eff_addr == `CFE_F_GPIO) gpio_q <= res_d[5:0];
      if (op == cfe_pkg::OP_TRIS) tris_q <= w_q[5:0];
    end
  end

  // general registers; writes to unimplemented slots never happen
  always_ff @(posedge sys_clk) begin
    if (exec_now && wr_file && eff_addr >= `CFE_F_GPR) begin
      gpr_q[gpr_slot(eff_addr, ptr_bank)] <= res_d; // see (RL12) (RL13) (RL14)
    end
  end

  // timer: instruction cycles or rising edges on pin two
  always_ff @(posedge sys_clk) begin
    if (core_rst) begin
      timer_q <= 8'h00;
    end else if (exec_now && wr_file && eff_addr == `CFE_F_TIMER) begin
      timer_q <= res_d;
    end else if (cfg_q[`CFE_CFG_TEXT]) begin
      if (pin_sync_q[2] && !pin_prev_q[2]) timer_q <= timer_q + 8'h01; // see (RL17)
    end else if (phases.phase_four) begin
      timer_q <= timer_q + 8'h01;
    end
  end

  // sleep and wake on change of an enabled pin
  always_ff @(posedge sys_clk) begin
    if (!rst_n || master_clear_n_hit || prog_sync_q || wake_q) begin
      sleeping_q <= 1'b0;
      wake_q <= 1'b0;
      pin_snap_q <= 6'h00;
    end else if (exec_now && op == cfe_pkg::OP_SLEEP) begin
      sleeping_q <= 1'b1;
      pin_snap_q <= pin_sync_q;
    end else if (sleeping_q && |((pin_sync_q ^ pin_snap_q) & wake_en_q)) begin
      wake_q <= 1'b1; // see (RL16)
    end
  end

  // pin functions
  always_comb begin
    port_pin_drive.out = gpio_q;
    port_pin_drive.oe_n = tris_q;
    if (prog_sync_q) port_pin_drive.oe_n[1:0] = 2'h3; // see (RL15)
    if (cfg_q[`CFE_CFG_TEXT]) port_pin_drive.oe_n[2] = 1'b1; // see (RL17)
    port_pin_drive.oe_n[3] = 1'b1; // see (RL18)
    if (osc_output_en) port_pin_drive.oe_n[4] = 1'b1; // see (RL20)
    if (osc_input_sel) port_pin_drive.oe_n[5] = 1'b1; // see (RL21)
    pullup_en = pull_q; // see (RL16)
    if (cfg_q[`CFE_CFG_MASTER_CLEAR_N]) pullup_en[3] = 1'b1; // see (RL19)
  end
  assign osc_output_en = osc_mode == cfe_pkg::OSC_XT || osc_mode == cfe_pkg::OSC_LP;
  assign osc_input_sel = osc_mode != cfe_pkg::OSC_INTRC;
  assign pin01_schmitt = prog_sync_q; // see (RL15)
  assign ser_prog_clk = prog_sync_q && pin_sync_q[0];
  assign ser_prog_dat = prog_sync_q && pin_sync_q[1];

  // apb writes, taken in the access phase
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cfg_q <= `CFE_CFG_RST;
      pull_q <= 6'h00;
      wake_en_q <= 6'h00;
    end else if (psel && penable && pwrite) begin
      if (paddr == `CFE_REG_CONFIG) cfg_q <= pwdata[3:0];
      if (paddr == `CFE_REG_PINS) begin
        pull_q <= pwdata[`CFE_PINS_PULL_LO +: 6];
        wake_en_q <= pwdata[`CFE_PINS_WAKE_LO +: 6];
      end
    end
  end

  // apb read data and error captured in the setup phase
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (psel && !penable) begin
      pslverr_q <= 1'b0;
      case (paddr)
        `CFE_REG_CONFIG: prdata_q <= {28'h0, cfg_q};
        `CFE_REG_PINS: prdata_q <= {18'h0, wake_en_q, 2'h0, pull_q};
        `CFE_REG_CORE: prdata_q <= {6'h0, core_rst, sleeping_q, status_q, 4'h0, pc_q};
        `CFE_REG_WORK: prdata_q <= {timer_q, 2'h0, gpio_q, 2'h0, tris_q, w_q};
        default: begin
          prdata_q <= 32'h0000_0000;
          pslverr_q <= 1'b1;
        end
      endcase
    end
  end
  assign prdata = prdata_q;
  assign pslverr = pslverr_q && psel && penable;
  assign pready = 1'b1;

endmodule

`default_nettype wire

// ### cfe_core_assertions.sv
// port checker for the fetch/execute sequencer
// assumes a bind from the bench top onto cfe_core
`include "cfe_params.svh"
`timescale 1ns/1ps
`default_nettype none
module cfe_core_checker #(
  parameter bit LARGE_VARIANT = 1'h1
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [11:0] prog_addr,
  input wire logic [5:0] port_pin_in,
  input wire cfe_pkg::cfe_pin_drive_t port_pin_drive,
  input wire logic [5:0] pullup_en,
  input wire logic pin01_schmitt,
  input wire logic prog_mode,
  input wire logic ser_prog_clk,
  input wire logic ser_prog_dat,
  input wire logic osc_output_en,
  input wire logic osc_input_sel,
  input wire cfe_pkg::cfe_phases_t phases,
  input wire logic core_in_reset
);
  logic [3:0] cfg_q;
  logic [13:0] pins_q;
  logic wr;
  // shadow copies of the config and pin option words
  assign wr = psel && penable && pwrite;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cfg_q <= `CFE_CFG_RST;
      pins_q <= 14'h0000;
    end else if (wr && paddr == `CFE_REG_CONFIG) begin
      cfg_q <= pwdata[3:0];
    end else if (wr && paddr == `CFE_REG_PINS) begin
      pins_q <= pwdata[13:0];
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  phase_order_a: assert property (disable iff (!rst_n || core_in_reset)
    phases.phase_one && !core_in_reset |=> phases.phase_two ##1 phases.phase_three
      ##1 phases.phase_four)
    else $error("phase strobes out of order");
  phase_onehot_a: assert property ($onehot0(phases))
    else $error("phase strobes overlap");
  fetch_hold_a: assert property (disable iff (!rst_n || core_in_reset)
    !phases.phase_two && !$past(core_in_reset) |-> $stable(prog_addr))
    else $error("fetch address moved outside phase one");
  addr_wrap_a: assert property (
    (prog_addr & ~(LARGE_VARIANT ? `CFE_LARGE_MASK : `CFE_SMALL_MASK)) == 12'h000)
    else $error("fetch address beyond implemented space");
  reset_vector_a: assert property (
    $past(core_in_reset) && core_in_reset |-> prog_addr == `CFE_RESET_VECTOR)
    else $error("fetch address not zero in reset");
  pull_map_a: assert property (
    pullup_en == {pins_q[5:4], pins_q[3] | cfg_q[`CFE_CFG_MASTER_CLEAR_N], pins_q[2:0]})
    else $error("pull-up enables wrong");
  pin3_input_a: assert property (port_pin_drive.oe_n[3])
    else $error("pin three driven");
  master_clear_n_reset_a: assert property (
    (!port_pin_in[3] && cfg_q[`CFE_CFG_MASTER_CLEAR_N]) [*4] |-> core_in_reset)
    else $error("master clear ignored");
  timer_pin_a: assert property (cfg_q[`CFE_CFG_TEXT] |-> port_pin_drive.oe_n[2])
    else $error("timer clock pin driven");
  osc_pins_a: assert property (
    osc_output_en == cfg_q[1] && osc_input_sel == (cfg_q[1:0] != 2'h0))
    else $error("oscillator pin roles wrong");
  prog_pins_a: assert property (
    (prog_mode && $stable(port_pin_in)) [*4] |-> pin01_schmitt
      && ser_prog_clk == port_pin_in[0] && ser_prog_dat == port_pin_in[1])
    else $error("programming pins wrong");
  apb_answer_a: assert property (psel && penable |-> pready
      && pslverr == !(paddr inside {`CFE_REG_CONFIG, `CFE_REG_PINS,
      `CFE_REG_CORE, `CFE_REG_WORK}))
    else $error("bus answer wrong");
  // main scenarios reached
  cyc_c: cover property (phases.phase_four ##1 phases.phase_one);
  err_c: cover property (psel && penable && pslverr);
  master_clear_n_c: cover property (rst_n && core_in_reset);
endmodule
`default_nettype wire

// ### cfe_params.svh
// constants of the fetch/execute sequencer: offsets, field positions, resets
// assumes inclusion by bare name from the core module, checker, memory model and bench
`ifndef CFE_PARAMS_SVH
`define CFE_PARAMS_SVH

// instruction cycle: oscillator periods per cycle
`define CFE_PHASES 4
// program counter and implemented program space
`define CFE_PC_W 12
`define CFE_RESET_VECTOR 12'h000
`define CFE_SMALL_MASK 12'h1FF
`define CFE_LARGE_MASK 12'h3FF
// file addresses
`define CFE_F_INDF 5'h00
`define CFE_F_TIMER 5'h01
`define CFE_F_PCL 5'h02
`define CFE_F_STATUS 5'h03
`define CFE_F_POINTER 5'h04
`define CFE_F_OSCCAL 5'h05
`define CFE_F_GPIO 5'h06
`define CFE_F_GPR 5'h07
`define CFE_F_BANKED 5'h10
`define CFE_GPR_SLOTS 41
// status bit positions and reset value
`define CFE_ST_WAKE 7
`define CFE_ST_PAGE 5
`define CFE_ST_TO 4
`define CFE_ST_PD 3
`define CFE_ST_Z 2
`define CFE_ST_DC 1
`define CFE_ST_C 0
`define CFE_STATUS_RST 8'h18
`define CFE_PTR_BANK 5
`define CFE_OSCCAL_RST 8'h70
`define CFE_TRIS_RST 6'h3F
// apb register byte offsets
`define CFE_REG_CONFIG 12'h000
`define CFE_REG_PINS 12'h004
`define CFE_REG_CORE 12'h008
`define CFE_REG_WORK 12'h00C
// config fields
`define CFE_CFG_OSC_LO 0
`define CFE_CFG_MASTER_CLEAR_N 2
`define CFE_CFG_TEXT 3
`define CFE_CFG_RST 4'h4
// pin option fields
`define CFE_PINS_PULL_LO 0
`define CFE_PINS_WAKE_LO 8

`endif

// ### cfe_pkg.sv
// types shared by the fetch/execute sequencer
// assumes nothing beyond a SystemVerilog compiler
package cfe_pkg;

  // the four phases of one instruction cycle
  typedef enum logic [1:0] {PH_ONE, PH_TWO, PH_THREE, PH_FOUR} cfe_phase_t;

  // oscillator configuration
  typedef enum logic [1:0] {OSC_INTRC, OSC_EXTRC, OSC_XT, OSC_LP} cfe_osc_t;

  // executed operations
  typedef enum logic [3:0] {
    OP_NOP, OP_GOTO, OP_MOVLW, OP_MOVWF, OP_CLRF, OP_MOVF, OP_INCF,
    OP_ADDWF, OP_BCF, OP_BSF, OP_SLEEP, OP_TRIS
  } cfe_op_t;

  // drive of the six port pins
  typedef struct packed {
    logic [5:0] out;
    logic [5:0] oe_n;
  } cfe_pin_drive_t;

  // phase strobes
  typedef struct packed {
    logic phase_one;
    logic phase_two;
    logic phase_three;
    logic phase_four;
  } cfe_phases_t;

endpackage

// ### cfe_prog_mem.sv
// program memory model answering fetches at once
// assumes the bench fills words through load before reset ends
`include "cfe_params.svh"
`timescale 1ns/1ps
`default_nettype none
module cfe_prog_mem (
  input wire logic [11:0] prog_addr,
  output logic [11:0] prog_data
);
  // all words start as no-operations, set before any load can run
  logic [11:0] words [0:2047] = '{default: 12'h000};
  // combinational read of the addressed word
  assign prog_data = words[prog_addr];
  // fill one word, keeping the calibration word intact
  task automatic load(input logic [11:0] a, input logic [11:0] w);
    if (a != `CFE_LARGE_MASK) words[a] = w;
  endtask
endmodule
`default_nettype wire

// ### core_fetch_exec_memory_map_tb_top.sv
// self-checking bench for the fetch/execute sequencer
// assumes core, program memory model and checker compiled before
`include "cfe_params.svh"
`timescale 1ns/1ps
`default_nettype none
module core_fetch_exec_memory_map_tb_top;
  typedef struct packed {
    logic wr;
    logic [11:0] addr;
    logic [31:0] data;
    logic [31:0] exp;
    logic err;
  } cfe_row_t;
  localparam logic [11:0] GOTO_OP = 12'hA00; // opcode base of a jump
  localparam logic [11:0] MOVLW_OP = 12'hC00; // opcode base of a literal load
  // code at the jump target: store w, bank via pointer, add, indirect read, tris,
  // increment, bit set, read back, port write; ends with w b4, tris 10, port 34
  localparam logic [11:0] PROG_TAIL [13] = '{12'h027, 12'hC30, 12'h024, 12'hC09,
    12'h020, 12'hC07, 12'h1F0, 12'h200, 12'h006, 12'h2A7, 12'h5E7, 12'h207, 12'h026};
  logic sys_clk = 1'h0;
  logic rst_n = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [31:0] pwdata = 32'h0;
  logic [5:0] port_pin_in = 6'h3F;
  logic prog_mode = 1'h0;
  logic [31:0] prdata;
  logic pready, pslverr, pin01_schmitt, ser_prog_clk, ser_prog_dat;
  logic osc_output_en, osc_input_sel, core_in_reset, rerr;
  logic [11:0] prog_addr, prog_data, exp_a;
  logic [5:0] pullup_en;
  logic [31:0] rd;
  cfe_pkg::cfe_pin_drive_t port_pin_drive;
  cfe_pkg::cfe_phases_t phases;
  int miscompares = 0;
  int compares = 0;
  cfe_row_t rows [7];
  cfe_core #(.LARGE_VARIANT(1'h1)) dut_u (.sys_clk, .rst_n, .paddr, .psel, .penable,
    .pwrite, .pwdata, .prdata, .pready, .pslverr, .prog_addr, .prog_data, .port_pin_in,
    .port_pin_drive, .pullup_en, .pin01_schmitt, .prog_mode, .ser_prog_clk,
    .ser_prog_dat, .osc_output_en, .osc_input_sel, .phases, .core_in_reset);
  cfe_prog_mem mem_u (.prog_addr, .prog_data);
  // free-running clock
  always #50 sys_clk = ~sys_clk;
  // verdict and end of run
  task automatic print_verdict();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // one counted comparison
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one bus transfer, answer taken at the ready edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'h1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'h1 && n < 50);
    rd = prdata;
    rerr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    if (n >= 50) begin
      miscompares++;
      print_verdict();
    end
  endtask
  // bounded wait for a flag, phase two or core reset, ending at the edge that sees it
  task automatic wait_flag(input int which, input logic val);
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while ((which == 0 ? phases.phase_two : core_in_reset) !== val && n < 40);
    if (n >= 40) begin
      miscompares++;
      print_verdict();
    end
  endtask
  // main sequence
  initial begin
    rows = '{'{1'h0, `CFE_REG_CONFIG, 32'h0, 32'h4, 1'h0},
      '{1'h1, `CFE_REG_PINS, 32'h2A15, 32'h0, 1'h0},
      '{1'h0, `CFE_REG_PINS, 32'h0, 32'h2A15, 1'h0},
      '{1'h1, `CFE_REG_CONFIG, 32'hB, 32'h0, 1'h0},
      '{1'h0, `CFE_REG_CONFIG, 32'h0, 32'hB, 1'h0},
      '{1'h0, 12'h010, 32'h0, 32'h0, 1'h1},
      '{1'h1, 12'h010, 32'h5A, 32'h0, 1'h1}};
    mem_u.load(12'h001, MOVLW_OP | 12'h033);
    mem_u.load(12'h003, GOTO_OP | 12'h010);
    mem_u.load(12'h004, MOVLW_OP | 12'h055);
    for (int i = 0; i < 13; i++) begin
      mem_u.load(12'(12'h010 + i), PROG_TAIL[i]);
    end
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'h1;
    exp_a = `CFE_RESET_VECTOR;
    for (int i = 0; i < 1100; i++) begin
      wait_flag(0, 1'h1);
      chk("fetch address", 32'(exp_a), 32'(prog_addr));
      exp_a = (exp_a == 12'h004) ? 12'h010 : (exp_a + 12'h001) & `CFE_LARGE_MASK;
    end
    apb(1'h0, `CFE_REG_WORK, 32'h0);
    chk("working value", 32'hB4, 32'(rd[7:0]));
    chk("work fields", 32'h0034_10B4, rd & 32'h003F_3FFF);
    chk("pin drive", 32'h34, 32'(port_pin_drive.out));
    chk("pin enables", 32'h18, 32'(port_pin_drive.oe_n));
    apb(1'h0, `CFE_REG_CORE, 32'h0);
    chk("status flags", 32'h01A, 32'(rd[25:16]));
    $display("fetch trace done");
    for (int i = 0; i < 7; i++) begin
      apb(rows[i].wr, rows[i].addr, rows[i].data);
      if (!rows[i].wr) chk("read data", rows[i].exp, rd);
      chk("error flag", 32'(rows[i].err), 32'(rerr));
    end
    $display("register table done");
    for (int m = 0; m < 4; m++) begin
      apb(1'h1, `CFE_REG_CONFIG, 32'(m));
      @(negedge sys_clk);
      chk("crystal output", 32'(m[1]), 32'(osc_output_en));
      chk("oscillator input", 32'(m != 0), 32'(osc_input_sel));
      chk("pull-ups", 32'h15, 32'(pullup_en));
    end
    apb(1'h1, `CFE_REG_CONFIG, 32'hC);
    @(negedge sys_clk);
    chk("forced pull-up", 32'h1D, 32'(pullup_en));
    chk("timer pin released", 32'h1, 32'(port_pin_drive.oe_n[2]));
    @(posedge sys_clk);
    port_pin_in <= 6'h37;
    wait_flag(1, 1'h1);
    port_pin_in <= 6'h3F;
    wait_flag(1, 1'h0);
    wait_flag(0, 1'h1);
    chk("restart address", 32'h0, 32'(prog_addr));
    $display("master clear done");
    prog_mode <= 1'h1;
    port_pin_in <= 6'h3D;
    repeat (5) @(posedge sys_clk);
    @(negedge sys_clk);
    chk("hysteresis select", 32'h1, 32'(pin01_schmitt));
    chk("serial clock", 32'h1, 32'(ser_prog_clk));
    chk("serial data", 32'h0, 32'(ser_prog_dat));
    @(posedge sys_clk);
    prog_mode <= 1'h0;
    rst_n <= 1'h0;
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'h1;
    wait_flag(0, 1'h1);
    chk("reset address", 32'h0, 32'(prog_addr));
    apb(1'h0, `CFE_REG_CONFIG, 32'h0);
    chk("config reset value", 32'h4, rd);
    $display("second reset done");
    print_verdict();
  end
endmodule
bind cfe_core cfe_core_checker #(.LARGE_VARIANT(LARGE_VARIANT)) chk_u (.sys_clk, .rst_n,
  .paddr, .psel, .penable, .pwrite, .pwdata, .pready, .pslverr, .prog_addr, .port_pin_in,
  .port_pin_drive, .pullup_en, .pin01_schmitt, .prog_mode, .ser_prog_clk, .ser_prog_dat,
  .osc_output_en, .osc_input_sel, .phases, .core_in_reset);
`default_nettype wire
